// [hw/tci_interlock.sv]
// Tool magazine and spindle interlock with latched alarms and timeouts.
// Assumes sensors and panel buttons arrive asynchronously on pins, while
// requests, Z state, tool numbers and settings come from clk_sys logic.
`timescale 1ns/10ps
module tci_interlock
   import tci_pkg::*;
#(
   parameter int CYCLES_PER_MS = CYCLES_PER_MS_DEF
)
(
   input logic clk_sys,
   input logic rst,
   input logic forward_inpos_sensor,
   input logic retract_inpos_sensor,
   input logic pocket_count_switch,
   input logic pocket_tool_present_sensor,
   input logic tool_release_sensor,
   input logic tool_clamp_sensor,
   input logic spindle_tool_present_sensor,
   input logic orientation_done_input,
   input logic position_mode_done_input,
   input logic velocity_mode_done_input,
   input logic start_button,
   input logic operator_reset_button,
   input logic infeed_req,
   input logic retract_req,
   input logic z_move_req,
   input logic z_origin_return_req,
   input logic z_toolchange_return_req,
   input logic rotate_fwd_req,
   input logic rotate_rev_req,
   input logic tool_change_code,
   input logic position_mode_code,
   input logic velocity_mode_code,
   input logic orient_cmd,
   input logic z_zero_return_done,
   input logic estop_active,
   input logic auto_mode,
   input logic z_at_origin,
   input logic z_at_toolchange,
   input logic z_beyond_toolchange,
   input logic [7:0] spindle_tool_number,
   input logic [7:0] current_pocket_counter,
   input logic magazine_debug_enable,
   input logic manual_toolchange_return_enable,
   input logic tool_presence_detect_enable,
   input logic [TMR_W-1:0] position_mode_timeout,
   input logic [TMR_W-1:0] velocity_mode_timeout,
   input logic [TMR_W-1:0] rotation_pulse_timeout,
   input logic [TMR_W-1:0] count_switch_stuck_timeout,
   output logic [NALM-1:0] alarm_q,
   output logic infeed_out,
   output logic retract_out,
   output logic z_move_allow,
   output logic z_origin_return_allow,
   output logic z_toolchange_return_allow,
   output logic tool_change_allow,
   output logic cycle_start_out,
   output logic magazine_forward_rotate_out,
   output logic magazine_reverse_rotate_out
);

   typedef struct packed {
      logic [NSYNC-1:0] s1;
      logic [NSYNC-1:0] s2;
      logic [NSYNC-1:0] s3;
      logic [NSYNC-1:0] clean;
      logic [PRESC_W-1:0] presc;
      logic tick;
      logic [NALM-1:0] alarm;
      logic z_ref;
      logic pos_pend;
      logic vel_pend;
      logic rot_wait;
      logic prev_cnt;
      logic prev_rot;
      logic prev_start;
      logic prev_debug;
      logic infeed;
      logic retract;
      logic zmove;
      logic zorg;
      logic ztc;
      logic tchg;
      logic start;
      logic rot_fwd;
      logic rot_rev;
   } tci_state_type;

   localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(CYCLES_PER_MS - 1);

   tci_state_type q;
   tci_state_type d;
   logic [NSYNC-1:0] pins;
   logic [NALM-1:0] set_v;
   logic [NALM-1:0] blk;
   logic [NTMR-1:0] t_run;
   logic [NTMR-1:0] t_restart;
   logic [NTMR-1:0] t_exp;
   logic [NTMR-1:0][TMR_W-1:0] t_limit;
   logic dbg;
   logic at_infeed;
   logic clamped;
   logic released;
   logic oriented;
   logic start_edge;
   logic rotating;
   logic cnt_edge;
   logic op_clear;

   assign pins = {operator_reset_button, start_button, velocity_mode_done_input,
                  position_mode_done_input, orientation_done_input,
                  spindle_tool_present_sensor, tool_clamp_sensor, tool_release_sensor,
                  pocket_tool_present_sensor, pocket_count_switch,
                  retract_inpos_sensor, forward_inpos_sensor};

   // ---------------------------------------------------------------
   // Timeout timers
   // ---------------------------------------------------------------
   tci_timer_if tif [NTMR] ();

   assign t_limit[T_POS] = position_mode_timeout;
   assign t_limit[T_VEL] = velocity_mode_timeout;
   assign t_limit[T_ROTP] = rotation_pulse_timeout;
   assign t_limit[T_STUCK] = count_switch_stuck_timeout;
   assign t_run = {rotating, q.rot_wait, q.vel_pend, q.pos_pend};
   assign t_restart = {cnt_edge || (rotating && !q.prev_rot),
                       rotating && !q.prev_rot, velocity_mode_code, position_mode_code};

   genvar gi;
   generate
      for (gi = 0; gi < NTMR; gi++)
      begin : g_tmr
         assign tif[gi].run = t_run[gi];
         assign tif[gi].restart = t_restart[gi];
         assign tif[gi].tick = q.tick;
         assign tif[gi].limit = t_limit[gi];
         assign t_exp[gi] = tif[gi].expired;
         tci_timer u_tmr (
            .clk_sys(clk_sys),
            .rst(rst),
            .tif(tif[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Condition decode
   // ---------------------------------------------------------------
   assign dbg = magazine_debug_enable;
   assign at_infeed = q.clean[S_FWD];
   assign clamped = q.clean[S_CLAMP];
   assign released = q.clean[S_REL];
   assign oriented = q.clean[S_ORIENT];
   assign start_edge = q.clean[S_START] && !q.prev_start;
   assign rotating = q.rot_fwd || q.rot_rev;
   assign cnt_edge = q.clean[S_CNT] != q.prev_cnt;
   assign op_clear = q.clean[S_OPRST];

   always_comb
   begin
      set_v = ALARM_RST;
      set_v[A_NOT_ORIENT] = infeed_req && !oriented;
      set_v[A_RET_RELEASED] = retract_req && released;
      set_v[A_OCCUPIED] = infeed_req && z_at_origin && spindle_tool_number != 8'h00;
      set_v[A_MISMATCH] = infeed_req && z_at_toolchange
                          && spindle_tool_number != current_pocket_counter;
      set_v[A_CLAMP_ZMOVE] = z_move_req && at_infeed && clamped;
      set_v[A_DEBUG_WARN] = dbg && !q.prev_debug;
      set_v[A_DEBUG_START] = start_edge && auto_mode && dbg;
      set_v[A_CLAMP_ORG] = z_origin_return_req && at_infeed && clamped;
      set_v[A_CLAMP_TC] = z_toolchange_return_req && at_infeed && clamped;
      set_v[A_UNORIENT_TC] = z_toolchange_return_req && at_infeed && !oriented;
      set_v[A_MANUAL_START] = start_edge && auto_mode && manual_toolchange_return_enable;
      set_v[A_OUT_ORIGIN] = retract_req && at_infeed && !z_at_origin;
      set_v[A_SAFETY] = at_infeed && z_beyond_toolchange;
      set_v[A_POS_TMO] = q.pos_pend && t_exp[T_POS];
      set_v[A_VEL_TMO] = q.vel_pend && t_exp[T_VEL];
      set_v[A_MAG_CONFLICT] = q.clean[S_FWD] && q.clean[S_RET];
      set_v[A_CLAMP_CONFLICT] = released && clamped;
      set_v[A_ORIENT_SEQ] = orient_cmd && oriented;
      set_v[A_NO_ZREF] = tool_change_code && !q.z_ref;
      set_v[A_ROTATION] = (q.rot_wait && t_exp[T_ROTP]) || (rotating && t_exp[T_STUCK]);
      set_v[A_SP_PRESENT] = tool_change_code && tool_presence_detect_enable
                            && spindle_tool_number == 8'h00 && q.clean[S_SPTOOL];
      set_v[A_POCKET_FULL] = infeed_req && tool_presence_detect_enable
                             && spindle_tool_number != 8'h00 && q.clean[S_POCKET];
      // Debug mode releases every magazine alarm and interlock at once.
      if (dbg)
      begin
         set_v = set_v & ~MAG_MASK;
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      d = q;
      d.s1 = pins;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // Each bit takes a change only once its two later stages agree, so a
      // chattering pin cannot hold back the others.
      d.clean = (q.s3 & ~(q.s2 ^ q.s3)) | (q.clean & (q.s2 ^ q.s3));
      d.tick = (q.presc == PRESC_LAST);
      d.presc = d.tick ? PRESC_RST : q.presc + 18'h00001;
      d.prev_cnt = q.clean[S_CNT];
      d.prev_rot = rotating;
      d.prev_start = q.clean[S_START];
      d.prev_debug = dbg;
      // Operator reset clears, but a fresh event in the same cycle wins.
      d.alarm = (op_clear ? ALARM_RST : q.alarm) | set_v;
      blk = dbg ? (d.alarm & ~MAG_MASK) : d.alarm;
      if (estop_active)
      begin
         d.z_ref = 1'b0;
      end
      else if (z_zero_return_done)
      begin
         d.z_ref = 1'b1;
      end
      if (position_mode_code)
      begin
         d.pos_pend = 1'b1;
      end
      else if (q.clean[S_POSDONE] || set_v[A_POS_TMO])
      begin
         d.pos_pend = 1'b0;
      end
      if (velocity_mode_code)
      begin
         d.vel_pend = 1'b1;
      end
      else if (q.clean[S_VELDONE] || set_v[A_VEL_TMO])
      begin
         d.vel_pend = 1'b0;
      end
      if (rotating && !q.prev_rot)
      begin
         d.rot_wait = 1'b1;
      end
      else if (cnt_edge || !rotating)
      begin
         d.rot_wait = 1'b0;
      end
      // Each grant drops in the same edge that latches its alarm.
      d.infeed = infeed_req && ((blk & INFEED_MASK) == ALARM_RST);
      d.retract = retract_req && ((blk & RETRACT_MASK) == ALARM_RST);
      d.zmove = z_move_req && ((blk & ZMOVE_MASK) == ALARM_RST);
      d.zorg = z_origin_return_req && ((blk & ZORG_MASK) == ALARM_RST);
      d.ztc = z_toolchange_return_req && ((blk & ZTC_MASK) == ALARM_RST);
      d.tchg = tool_change_code && ((blk & TCHG_MASK) == ALARM_RST);
      d.start = start_edge && !(auto_mode && (dbg || manual_toolchange_return_enable))
                && ((blk & START_MASK) == ALARM_RST);
      d.rot_fwd = rotate_fwd_req && ((blk & ROT_MASK) == ALARM_RST);
      d.rot_rev = rotate_rev_req && !rotate_fwd_req
                  && ((blk & ROT_MASK) == ALARM_RST);
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign alarm_q = q.alarm;
   assign infeed_out = q.infeed;
   assign retract_out = q.retract;
   assign z_move_allow = q.zmove;
   assign z_origin_return_allow = q.zorg;
   assign z_toolchange_return_allow = q.ztc;
   assign tool_change_allow = q.tchg;
   assign cycle_start_out = q.start;
   assign magazine_forward_rotate_out = q.rot_fwd;
   assign magazine_reverse_rotate_out = q.rot_rev;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   infeed_orient_a: assert property (
      infeed_req && !dbg && !oriented |=> alarm_q[A_NOT_ORIENT] && !infeed_out)
      else $error("infeed granted with spindle not oriented");
   retract_rel_a: assert property (
      retract_req && !dbg && released |=> alarm_q[A_RET_RELEASED] && !retract_out)
      else $error("retract granted while tool released");
   spindle_occupied_a: assert property (
      infeed_req && !dbg && z_at_origin && spindle_tool_number != 8'h00
      |=> alarm_q[A_OCCUPIED] && !infeed_out)
      else $error("infeed granted with occupied spindle");
   clamp_zmove_a: assert property (
      z_move_req && !dbg && at_infeed && clamped |=> alarm_q[A_CLAMP_ZMOVE] && !z_move_allow)
      else $error("clamped Z move not flagged");
   debug_warn_a: assert property (
      $rose(magazine_debug_enable) |=> alarm_q[A_DEBUG_WARN])
      else $error("debug warning not raised");
   debug_start_a: assert property (
      start_edge && auto_mode && dbg |=> alarm_q[A_DEBUG_START] && !cycle_start_out)
      else $error("cycle started in debug mode");
   mag_conflict_a: assert property (
      q.clean[S_FWD] && q.clean[S_RET] && !dbg |=> alarm_q[A_MAG_CONFLICT])
      else $error("magazine sensor conflict missed");
   clamp_conflict_a: assert property (
      released && clamped |=> alarm_q[A_CLAMP_CONFLICT])
      else $error("clamp sensor conflict missed");
   z_reference_a: assert property (
      tool_change_code && !q.z_ref |=> alarm_q[A_NO_ZREF] && !tool_change_allow)
      else $error("tool change allowed without Z reference");
   rot_stop_a: assert property (
      alarm_q[A_ROTATION] && !$past(dbg) |-> !magazine_forward_rotate_out
      && !magazine_reverse_rotate_out)
      else $error("magazine rotates under rotation alarm");
   alarm_hold_a: assert property (
      !op_clear |=> (alarm_q & $past(alarm_q)) == $past(alarm_q))
      else $error("alarm bit dropped without operator reset");

   infeed_ok_c: cover property (infeed_req ##1 infeed_out);
   rot_alarm_c: cover property (rotating ##[1:1000] alarm_q[A_ROTATION]);
   pos_tmo_c: cover property (position_mode_code ##[1:1000] alarm_q[A_POS_TMO]);
   clear_c: cover property (alarm_q != ALARM_RST ##1 op_clear ##2 alarm_q == ALARM_RST);

endmodule : tci_interlock

// [hw/tci_pkg.sv]
// Constants shared by the tool-change interlock block and its timeout timer.
// Assumes a single 250 MHz scan clock and millisecond timeout settings.
package tci_pkg;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int MS_NS = 1000000;
   localparam int CYCLES_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
   localparam int PRESC_W = 18;
   localparam int TMR_W = 16;

   // -----------------------------------------------------------------
   // Synchronised pin inputs, bit positions
   // -----------------------------------------------------------------
   localparam int NSYNC = 12;
   localparam int S_FWD = 0;
   localparam int S_RET = 1;
   localparam int S_CNT = 2;
   localparam int S_POCKET = 3;
   localparam int S_REL = 4;
   localparam int S_CLAMP = 5;
   localparam int S_SPTOOL = 6;
   localparam int S_ORIENT = 7;
   localparam int S_POSDONE = 8;
   localparam int S_VELDONE = 9;
   localparam int S_START = 10;
   localparam int S_OPRST = 11;
   localparam logic [NSYNC-1:0] SYNC_RST = 12'h000;

   // -----------------------------------------------------------------
   // Alarm bit positions
   // -----------------------------------------------------------------
   localparam int NALM = 22;
   localparam int A_NOT_ORIENT = 0;
   localparam int A_RET_RELEASED = 1;
   localparam int A_OCCUPIED = 2;
   localparam int A_MISMATCH = 3;
   localparam int A_CLAMP_ZMOVE = 4;
   localparam int A_DEBUG_WARN = 5;
   localparam int A_DEBUG_START = 6;
   localparam int A_CLAMP_ORG = 7;
   localparam int A_CLAMP_TC = 8;
   localparam int A_UNORIENT_TC = 9;
   localparam int A_MANUAL_START = 10;
   localparam int A_OUT_ORIGIN = 11;
   localparam int A_SAFETY = 12;
   localparam int A_POS_TMO = 13;
   localparam int A_VEL_TMO = 14;
   localparam int A_MAG_CONFLICT = 15;
   localparam int A_CLAMP_CONFLICT = 16;
   localparam int A_ORIENT_SEQ = 17;
   localparam int A_NO_ZREF = 18;
   localparam int A_ROTATION = 19;
   localparam int A_SP_PRESENT = 20;
   localparam int A_POCKET_FULL = 21;
   localparam logic [NALM-1:0] ALARM_RST = 22'h000000;

   // Alarms and interlocks that magazine debug mode suspends.
   localparam logic [NALM-1:0] MAG_MASK = 22'h289B9F;
   // Alarms that hold each motion blocked while latched.
   localparam logic [NALM-1:0] INFEED_MASK = 22'h20000D;
   localparam logic [NALM-1:0] RETRACT_MASK = 22'h000802;
   localparam logic [NALM-1:0] ZMOVE_MASK = 22'h001010;
   localparam logic [NALM-1:0] ZORG_MASK = 22'h000080;
   localparam logic [NALM-1:0] ZTC_MASK = 22'h000300;
   localparam logic [NALM-1:0] TCHG_MASK = 22'h140000;
   localparam logic [NALM-1:0] START_MASK = 22'h000440;
   localparam logic [NALM-1:0] ROT_MASK = 22'h080000;

   // -----------------------------------------------------------------
   // Timer channels
   // -----------------------------------------------------------------
   localparam int NTMR = 4;
   localparam int T_POS = 0;
   localparam int T_VEL = 1;
   localparam int T_ROTP = 2;
   localparam int T_STUCK = 3;
   localparam logic [TMR_W-1:0] TMR_CNT_RST = 16'h0000;
   localparam logic [TMR_W-1:0] TMR_CNT_MAX = 16'hFFFF;
   localparam logic [PRESC_W-1:0] PRESC_RST = 18'h00000;

endpackage : tci_pkg

// [hw/tci_timer.sv]
// Millisecond timeout timer: counts ticks while running, flags expiry.
// Assumes tick is a one-cycle pulse once per millisecond on clk_sys.
`timescale 1ns/10ps
module tci_timer
   import tci_pkg::*;
(
   input logic clk_sys,
   input logic rst,
   tci_timer_if.tmr tif
);

   typedef struct packed {
      logic [TMR_W-1:0] cnt;
      logic expired;
   } tci_tmr_state_type;

   tci_tmr_state_type q;
   tci_tmr_state_type d;

   // ---------------------------------------------------------------
   // Counting
   // ---------------------------------------------------------------
   // The count saturates so a long stall cannot wrap and hide expiry.
   always_comb
   begin
      d = q;
      if (!tif.run || tif.restart)
      begin
         d.cnt = TMR_CNT_RST;
         d.expired = 1'b0;
      end
      else
      begin
         if (tif.tick && q.cnt != TMR_CNT_MAX)
         begin
            d.cnt = q.cnt + 16'h0001;
         end
         d.expired = (q.cnt >= tif.limit);
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         q <= '{cnt: TMR_CNT_RST, expired: 1'b0};
      end
      else
      begin
         q <= d;
      end
   end

   assign tif.expired = q.expired;

endmodule : tci_timer

// [hw/tci_timer_if.sv]
// Link between the interlock core and one millisecond timeout timer.
// Assumes the core drives the control side and the timer answers.
`timescale 1ns/10ps
interface tci_timer_if;
   import tci_pkg::*;
   logic restart;
   logic run;
   logic tick;
   logic [TMR_W-1:0] limit;
   logic expired;
   modport ctl (output restart, output run, output tick, output limit, input expired);
   modport tmr (input restart, input run, input tick, input limit, output expired);
endinterface : tci_timer_if

// [tb/tci_machine_model.sv]
// Machine-side model: magazine slide sensors, pocket count switch, spindle mode answers.
// Assumes the interlock outputs are registered on clk_sys; fault mutes the answers.
`timescale 1ns/10ps
module tci_machine_model
(
   input logic clk_sys,
   input logic rst,
   input logic fault,
   input logic infeed_out,
   input logic retract_out,
   input logic rot_on,
   input logic pos_cmd,
   input logic vel_cmd,
   output logic fwd_s,
   output logic ret_s,
   output logic cnt_s,
   output logic pos_d,
   output logic vel_d
);
   logic [2:0] cnt_q;
   logic [3:0] pd_q;
   logic [3:0] vd_q;
   // The slide holds its last end position, so sensors keep the state.
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
      begin
         fwd_s <= 1'b0;
         cnt_s <= 1'b0;
         cnt_q <= 3'h0;
         pd_q <= 4'h0;
         vd_q <= 4'h0;
      end
      else
      begin
         fwd_s <= infeed_out | (fwd_s & ~retract_out);
         cnt_q <= (rot_on & ~fault) ? cnt_q + 3'h1 : cnt_q;
         cnt_s <= cnt_s ^ (rot_on & ~fault & (cnt_q == 3'h7));
         pd_q <= {pd_q[2:0], pos_cmd & ~fault};
         vd_q <= {vd_q[2:0], vel_cmd & ~fault};
      end
   assign ret_s = ~fwd_s;
   assign pos_d = |pd_q;
   assign vel_d = |vd_q;
endmodule : tci_machine_model

// [tb/testbench.sv]
// Self-checking bench for the tool-change interlock.
// Assumes the machine model on the sensor side and a 1 ms tick of 4 cycles.
`timescale 1ns/10ps
module testbench;
   import tci_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, fault = 1'b0, fwd_s, ret_s, cnt_s, pos_d, vel_d;
   logic pocket_tool_present_sensor = 1'b0, tool_release_sensor = 1'b0;
   logic tool_clamp_sensor = 1'b0, orientation_done_input = 1'b0, start_button = 1'b0;
   logic operator_reset_button = 1'b0, infeed_req = 1'b0, retract_req = 1'b0;
   logic rotate_fwd_req = 1'b0, tool_change_code = 1'b0, z_zero_return_done = 1'b0;
   logic position_mode_code = 1'b0, velocity_mode_code = 1'b0, auto_mode = 1'b0;
   logic z_at_origin = 1'b1, magazine_debug_enable = 1'b0;
   logic z_move_req = 1'b0, orient_cmd = 1'b0;
   logic manual_toolchange_return_enable = 1'b0;
   logic [7:0] spindle_tool_number = 8'h00;
   logic [TMR_W-1:0] tmo = 16'h0006;
   logic [NALM-1:0] alarm_q;
   logic infeed_out, retract_out, tool_change_allow, cycle_start_out, rot_f, rot_r, zm;
   int miscompares = 0;
   int samples_checked = 0;
   int starts = 0;
   tci_interlock #(.CYCLES_PER_MS(4)) uut (.clk_sys, .rst, .forward_inpos_sensor(fwd_s),
      .retract_inpos_sensor(ret_s), .pocket_count_switch(cnt_s), .pocket_tool_present_sensor,
      .tool_release_sensor, .tool_clamp_sensor, .spindle_tool_present_sensor(1'b0),
      .orientation_done_input, .position_mode_done_input(pos_d), .velocity_mode_done_input(vel_d),
      .start_button, .operator_reset_button, .infeed_req, .retract_req, .z_move_req,
      .z_origin_return_req(1'b0), .z_toolchange_return_req(1'b0), .rotate_fwd_req,
      .rotate_rev_req(1'b0), .tool_change_code, .position_mode_code, .velocity_mode_code,
      .orient_cmd, .z_zero_return_done, .estop_active(fault), .auto_mode, .z_at_origin,
      .z_at_toolchange(fault), .z_beyond_toolchange(fault), .spindle_tool_number,
      .current_pocket_counter(spindle_tool_number), .magazine_debug_enable,
      .manual_toolchange_return_enable, .tool_presence_detect_enable(fault),
      .position_mode_timeout(tmo), .velocity_mode_timeout(tmo), .rotation_pulse_timeout(tmo),
      .count_switch_stuck_timeout(tmo), .alarm_q, .infeed_out, .retract_out, .z_move_allow(zm),
      .z_origin_return_allow(), .z_toolchange_return_allow(), .tool_change_allow,
      .cycle_start_out, .magazine_forward_rotate_out(rot_f), .magazine_reverse_rotate_out(rot_r));
   tci_machine_model mach (.clk_sys, .rst, .fault, .infeed_out, .retract_out,
      .rot_on(rot_f | rot_r), .pos_cmd(position_mode_code), .vel_cmd(velocity_mode_code),
      .fwd_s, .ret_s, .cnt_s, .pos_d, .vel_d);
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
      if (cycle_start_out === 1'b1)
         starts <= starts + 1;
   // --------------------------------------------------------------
   // Shared tasks
   // --------------------------------------------------------------
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   // Sampling on the falling edge keeps clear of the update race.
   task automatic wait_alarm(input logic [NALM-1:0] exp);
      int i;
      for (i = 0; i < 100; i++)
      begin
         @(negedge clk_sys);
         if (alarm_q === exp)
            break;
      end
      chk(alarm_q, exp);
      if (i == 100)
         end_of_test();
   endtask : wait_alarm
   task automatic clear_alarms();
      cyc(1);
      operator_reset_button <= 1'b1;
      cyc(10);
      operator_reset_button <= 1'b0;
      cyc(8);
   endtask : clear_alarms
   task automatic req(input logic [1:0] sel, input logic v);
      cyc(1);
      if (sel == 2'h0) infeed_req <= v;
      if (sel == 2'h1) retract_req <= v;
      if (sel == 2'h2) tool_change_code <= v;
      if (sel == 2'h3) start_button <= v;
   endtask : req
   // --------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------
   task automatic s_infeed();
      req(0, 1);
      wait_alarm(22'h000001);
      chk(infeed_out, 1'b0);
      req(0, 0);
      orientation_done_input <= 1'b1;
      spindle_tool_number <= 8'h05;
      cyc(8);
      wait_alarm(22'h000001);
      clear_alarms();
      req(0, 1);
      wait_alarm(22'h000004);
      chk(infeed_out, 1'b0);
      req(0, 0);
      spindle_tool_number <= 8'h00;
      clear_alarms();
      wait_alarm(22'h000000);
      req(0, 1);
      cyc(3);
      chk(infeed_out, 1'b1);
      req(0, 0);
   endtask : s_infeed
   task automatic s_retract();
      cyc(6);
      z_at_origin <= 1'b0;
      req(1, 1);
      wait_alarm(22'h000800);
      chk(retract_out, 1'b0);
      req(1, 0);
      z_at_origin <= 1'b1;
      tool_release_sensor <= 1'b1;
      clear_alarms();
      req(1, 1);
      wait_alarm(22'h000002);
      req(1, 0);
      tool_release_sensor <= 1'b0;
      clear_alarms();
      req(1, 1);
      cyc(3);
      chk(retract_out, 1'b1);
      req(1, 0);
   endtask : s_retract
   task automatic s_start();
      magazine_debug_enable <= 1'b1;
      auto_mode <= 1'b1;
      wait_alarm(22'h000020);
      req(3, 1);
      cyc(8);
      req(3, 0);
      wait_alarm(22'h000060);
      chk(starts, 0);
      clear_alarms();
      wait_alarm(22'h000000);
      cyc(1);
      orientation_done_input <= 1'b0;
      req(0, 1);
      cyc(4);
      chk(infeed_out, 1'b1);
      chk(alarm_q, 22'h000000);
      req(0, 0);
      magazine_debug_enable <= 1'b0;
      orientation_done_input <= 1'b1;
      req(3, 1);
      cyc(8);
      req(3, 0);
      cyc(8);
      chk(starts, 1);
      manual_toolchange_return_enable <= 1'b1;
      req(3, 1);
      cyc(8);
      req(3, 0);
      wait_alarm(22'h000400);
      chk(starts, 1);
      cyc(1);
      manual_toolchange_return_enable <= 1'b0;
      auto_mode <= 1'b0;
      clear_alarms();
   endtask : s_start
   task automatic s_misc();
      tool_clamp_sensor <= 1'b1;
      cyc(6);
      z_move_req <= 1'b1;
      cyc(1);
      z_move_req <= 1'b0;
      wait_alarm(22'h000010);
      chk(zm, 1'b0);
      clear_alarms();
      // Retract now so the later Z-beyond stimulus finds the magazine clear.
      req(1, 1);
      req(1, 0);
      tool_release_sensor <= 1'b1;
      wait_alarm(22'h010000);
      cyc(1);
      tool_release_sensor <= 1'b0;
      tool_clamp_sensor <= 1'b0;
      clear_alarms();
      orient_cmd <= 1'b1;
      cyc(1);
      orient_cmd <= 1'b0;
      wait_alarm(22'h020000);
      clear_alarms();
      req(2, 1);
      wait_alarm(22'h040000);
      chk(tool_change_allow, 1'b0);
      req(2, 0);
      z_zero_return_done <= 1'b1;
      cyc(1);
      z_zero_return_done <= 1'b0;
      clear_alarms();
      req(2, 1);
      cyc(3);
      chk(tool_change_allow, 1'b1);
      req(2, 0);
      position_mode_code <= 1'b1;
      cyc(1);
      position_mode_code <= 1'b0;
      cyc(40);
      wait_alarm(22'h000000);
      cyc(1);
      fault <= 1'b1;
      velocity_mode_code <= 1'b1;
      cyc(1);
      velocity_mode_code <= 1'b0;
      wait_alarm(22'h004000);
      cyc(1);
      position_mode_code <= 1'b1;
      cyc(1);
      position_mode_code <= 1'b0;
      wait_alarm(22'h006000);
      cyc(1);
      fault <= 1'b0;
      clear_alarms();
   endtask : s_misc
   task automatic s_rotate();
      rotate_fwd_req <= 1'b1;
      cyc(60);
      chk(rot_f, 1'b1);
      wait_alarm(22'h000000);
      cyc(1);
      fault <= 1'b1;
      wait_alarm(22'h080000);
      chk(rot_f, 1'b0);
   endtask : s_rotate
   initial
   begin
      cyc(20);
      rst <= 1'b0;
      cyc(5);
      s_infeed();
      s_retract();
      s_start();
      s_misc();
      s_rotate();
      end_of_test();
   end
endmodule : testbench
